/* File: hdl/acmp_regs.svh */
// register offsets, field positions and reset values of the comparator control block
`ifndef ACMP_REGS_SVH
`define ACMP_REGS_SVH
// ==========================================
// register indices (byte address = 4 * index)
`define ACMP_IDX_CTRL_STATUS 8'h30
`define ACMP_IDX_INPUT_SEL 8'h31
`define ACMP_IDX_DIG_DISABLE 8'h32
`define ACMP_IDX_IRQ_STATUS 8'h33
`define ACMP_IDX_IRQ_MASK 8'h34
// ==========================================
// control and status fields
`define ACMP_BIT_POWER_OFF 7
`define ACMP_BIT_BANDGAP 6
`define ACMP_BIT_RESULT 5
`define ACMP_BIT_FLAG 4
`define ACMP_BIT_IRQ_EN 3
`define ACMP_BIT_CAPTURE 2
`define ACMP_BIT_MODE_HI 1
`define ACMP_BIT_MODE_LO 0
// ==========================================
// digital input disable fields
`define ACMP_BIT_NEG_BUF_OFF 1
`define ACMP_BIT_POS_BUF_OFF 0
// ==========================================
// irq status and mask fields
`define ACMP_IRQ_BIT_EVENT 0
`define ACMP_IRQ_BIT_RESERVED_SEL 1
// ==========================================
// reset values and last valid negative select code
`define ACMP_RST_CTRL 8'h00
`define ACMP_RST_INPUT_SEL 3'h0
`define ACMP_RST_DIG_DISABLE 2'h0
`define ACMP_RST_IRQ 2'h0
`define ACMP_NEG_SEL_LAST 3'h5
`endif

/* File: hdl/acmp_pkg.sv */
// types of the comparator control block
package acmp_pkg;
  // ==========================================
  // event modes
  typedef enum logic [1:0] {
    ACMP_MODE_TOGGLE = 2'h0,
    ACMP_MODE_RESVD = 2'h1,
    ACMP_MODE_FALL = 2'h2,
    ACMP_MODE_RISE = 2'h3
  } acmp_mode_t;
  // ==========================================
  // avalon-mm request carrier
  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } acmp_bus_req_t;
  // ==========================================
  // analog front-end controls
  typedef struct packed {
    logic power_off;
    logic bandgap_select;
    logic [2:0] neg_input_select;
    logic pos_buf_off;
    logic neg_buf_off;
  } acmp_analog_ctl_t;
  // ==========================================
  // bus answer state
  typedef enum logic [1:0] {
    ACMP_BUS_IDLE = 2'b01,
    ACMP_BUS_DONE = 2'b10
  } acmp_bus_state_t;
endpackage : acmp_pkg

/* File: hdl/acmp_control.sv */
// comparator control logic with avalon-mm register slave
//
// Contract
// [RULE_01] result high when positive input exceeds negative
// [RULE_02] power-off bit removes comparator power anytime
// [RULE_03] software disables irq before power change
// [RULE_04] bandgap bit selects reference as positive input
// [RULE_05] result synchronised, one to two cycles late
// [RULE_06] flag set on chosen synchronised output event
// [RULE_07] vector acknowledge clears the flag
// [RULE_08] writing one clears flag, zero keeps
// [RULE_09] irq needs flag, enable and global bit
// [RULE_10] capture enable routes result to timer capture
// [RULE_11] capture disabled means no timer connection
// [RULE_12] timer capture irq needs timer mask bit
// [RULE_13] mode 00 toggle, 10 fall, 11 rise
// [RULE_14] software disables irq before mode change
// [RULE_15] select codes 000-101 pick negative pins one-six
// [RULE_16] buffer-off bit disables buffer, pin reads zero
// [RULE_17] software disables unused analog pin buffers
// [RULE_18] control register resets zero, result read-only
// [RULE_19] edges found by current versus previous sample
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
`include "acmp_regs.svh"

module acmp_control
  import acmp_pkg::*;
(
  // clock, reset, enable
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic CLK_EN,
  // avalon-mm slave
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic AVS_RESPONSE_ERR,
  // analog comparator core
  input wire logic CMP_RAW_OUT,
  output logic CMP_POWER_OFF,
  output logic CMP_BANDGAP_SELECT,
  output logic [2:0] NEG_INPUT_SELECT,
  // pin buffers
  input wire logic POS_INPUT_PIN_DIG,
  input wire logic NEG_INPUT_PIN_ONE_DIG,
  output logic POS_PIN_BUFFER_OFF,
  output logic NEG_PIN_BUFFER_OFF,
  output logic POS_PIN_READ,
  output logic NEG_PIN_READ,
  // cpu interrupt handshake
  input wire logic CPU_GLOBAL_IRQ_EN,
  input wire logic CPU_VECTOR_ACK,
  output logic CMP_IRQ_REQ,
  // timer capture front end
  output logic CAPTURE_SRC_VALID,
  output logic CAPTURE_SRC_LEVEL,
  // system interrupt
  output logic IRQ
);

  // ==========================================
  // request carrier
  acmp_bus_req_t req;
  assign req = '{address: AVS_ADDRESS, read: AVS_READ, write: AVS_WRITE,
                 byteenable: AVS_BYTEENABLE, writedata: AVS_WRITEDATA};

  // ==========================================
  // synchronisers for outside inputs
  logic [1:0] res_sync_reg;
  logic [1:0] pos_pin_sync_reg;
  logic [1:0] neg_pin_sync_reg;
  logic result_prev_reg;

  // two flops each, first flop read only by second
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      res_sync_reg <= 2'h0;
      pos_pin_sync_reg <= 2'h0;
      neg_pin_sync_reg <= 2'h0;
      result_prev_reg <= 1'b0;
    end else if (CLK_EN) begin
      res_sync_reg <= {res_sync_reg[0], CMP_RAW_OUT}; // RULE_05
      pos_pin_sync_reg <= {pos_pin_sync_reg[0], POS_INPUT_PIN_DIG};
      neg_pin_sync_reg <= {neg_pin_sync_reg[0], NEG_INPUT_PIN_ONE_DIG};
      result_prev_reg <= res_sync_reg[1]; // RULE_19
    end
  end

  // ==========================================
  // synchronised result and event detect
  logic cmp_result_sync;
  logic rise_evt;
  logic fall_evt;
  logic cmp_event;

  // raw core output high means positive above negative
  assign cmp_result_sync = res_sync_reg[1]; // RULE_01
  assign rise_evt = cmp_result_sync & ~result_prev_reg; // RULE_19
  assign fall_evt = ~cmp_result_sync & result_prev_reg; // RULE_19

  // ==========================================
  // register state
  logic cmp_power_off_reg, cmp_power_off_next;
  logic cmp_bandgap_select_reg, cmp_bandgap_select_next;
  logic cmp_event_flag_reg, cmp_event_flag_next;
  logic cmp_irq_enable_reg, cmp_irq_enable_next;
  logic cmp_to_capture_enable_reg, cmp_to_capture_enable_next;
  acmp_mode_t mode_reg, mode_next;
  logic [2:0] neg_input_select_reg, neg_input_select_next;
  logic [1:0] buf_off_reg, buf_off_next;
  logic [1:0] irq_status_reg, irq_status_next;
  logic [1:0] irq_mask_reg, irq_mask_next;
  acmp_bus_state_t bus_state_reg, bus_state_next;
  logic [31:0] rdata_reg, rdata_next;
  logic err_reg, err_next;

  // ==========================================
  // event selection by mode
  always_comb begin
    case (mode_reg)
      ACMP_MODE_TOGGLE: cmp_event = rise_evt | fall_evt; // RULE_13
      ACMP_MODE_FALL: cmp_event = fall_evt; // RULE_13
      ACMP_MODE_RISE: cmp_event = rise_evt; // RULE_13
      default: cmp_event = 1'b0; // reserved mode, no event
    endcase
  end

  // ==========================================
  // bus decode
  logic [7:0] word_idx;
  logic access;
  logic hit;
  logic wr_low;
  logic is_ctrl;
  logic is_isel;
  logic is_dis;
  logic is_ist;
  logic is_imask;

  assign word_idx = {2'h0, req.address[7:2]};
  assign access = (req.read | req.write) & (bus_state_reg == ACMP_BUS_IDLE);
  assign is_ctrl = word_idx == `ACMP_IDX_CTRL_STATUS;
  assign is_isel = word_idx == `ACMP_IDX_INPUT_SEL;
  assign is_dis = word_idx == `ACMP_IDX_DIG_DISABLE;
  assign is_ist = word_idx == `ACMP_IDX_IRQ_STATUS;
  assign is_imask = word_idx == `ACMP_IDX_IRQ_MASK;
  assign hit = is_ctrl | is_isel | is_dis | is_ist | is_imask;
  assign wr_low = access & req.write & req.byteenable[0];

  // ==========================================
  // control and status next values
  always_comb begin
    cmp_power_off_next = cmp_power_off_reg;
    cmp_bandgap_select_next = cmp_bandgap_select_reg;
    cmp_event_flag_next = cmp_event_flag_reg;
    cmp_irq_enable_next = cmp_irq_enable_reg;
    cmp_to_capture_enable_next = cmp_to_capture_enable_reg;
    mode_next = mode_reg;
    neg_input_select_next = neg_input_select_reg;
    buf_off_next = buf_off_reg;
    irq_mask_next = irq_mask_reg;
    irq_status_next = irq_status_reg;
    if (wr_low && is_ctrl) begin
      cmp_power_off_next = req.writedata[`ACMP_BIT_POWER_OFF]; // RULE_02
      cmp_bandgap_select_next = req.writedata[`ACMP_BIT_BANDGAP]; // RULE_04
      cmp_irq_enable_next = req.writedata[`ACMP_BIT_IRQ_EN];
      cmp_to_capture_enable_next = req.writedata[`ACMP_BIT_CAPTURE];
      mode_next = acmp_mode_t'({req.writedata[`ACMP_BIT_MODE_HI],
                                req.writedata[`ACMP_BIT_MODE_LO]});
      if (req.writedata[`ACMP_BIT_FLAG]) begin
        cmp_event_flag_next = 1'b0; // RULE_08
      end
    end
    if (wr_low && is_isel) begin
      neg_input_select_next = req.writedata[2:0]; // RULE_15
    end
    if (wr_low && is_dis) begin
      buf_off_next = req.writedata[1:0]; // RULE_16
    end
    if (wr_low && is_imask) begin
      irq_mask_next = req.writedata[1:0];
    end
    // vector acknowledge clears the flag
    if (CPU_VECTOR_ACK) begin
      cmp_event_flag_next = 1'b0; // RULE_07
    end
    // read of status clears it
    if (access && req.read && is_ist) begin
      irq_status_next = 2'h0;
    end
    // hardware set wins over any clear
    if (cmp_event) begin
      cmp_event_flag_next = 1'b1; // RULE_06
      irq_status_next[`ACMP_IRQ_BIT_EVENT] = 1'b1;
    end
    if (wr_low && is_isel && req.writedata[2:0] > `ACMP_NEG_SEL_LAST) begin
      irq_status_next[`ACMP_IRQ_BIT_RESERVED_SEL] = 1'b1;
    end
  end

  // ==========================================
  // bus answer next values
  always_comb begin
    bus_state_next = bus_state_reg;
    rdata_next = rdata_reg;
    err_next = err_reg;
    case (bus_state_reg)
      ACMP_BUS_IDLE: begin
        if (req.read | req.write) begin
          bus_state_next = ACMP_BUS_DONE;
          err_next = ~hit;
          rdata_next = 32'h0000_0000;
          if (req.read) begin
            if (is_ctrl) begin
              rdata_next[7:0] = {cmp_power_off_reg, cmp_bandgap_select_reg,
                                 cmp_result_sync, cmp_event_flag_reg, // RULE_18
                                 cmp_irq_enable_reg, cmp_to_capture_enable_reg,
                                 mode_reg};
            end else if (is_isel) begin
              rdata_next[2:0] = neg_input_select_reg;
            end else if (is_dis) begin
              rdata_next[1:0] = buf_off_reg;
            end else if (is_ist) begin
              rdata_next[1:0] = irq_status_reg;
            end else if (is_imask) begin
              rdata_next[1:0] = irq_mask_reg;
            end
          end
        end
      end
      ACMP_BUS_DONE: begin
        bus_state_next = ACMP_BUS_IDLE;
      end
      default: begin
        bus_state_next = ACMP_BUS_IDLE;
      end
    endcase
  end

  // ==========================================
  // register all state
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cmp_power_off_reg <= 1'b0; // RULE_18
      cmp_bandgap_select_reg <= 1'b0;
      cmp_event_flag_reg <= 1'b0;
      cmp_irq_enable_reg <= 1'b0;
      cmp_to_capture_enable_reg <= 1'b0;
      mode_reg <= ACMP_MODE_TOGGLE;
      neg_input_select_reg <= `ACMP_RST_INPUT_SEL;
      buf_off_reg <= `ACMP_RST_DIG_DISABLE;
      irq_status_reg <= `ACMP_RST_IRQ;
      irq_mask_reg <= `ACMP_RST_IRQ;
      bus_state_reg <= ACMP_BUS_IDLE;
      rdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
    end else if (CLK_EN) begin
      cmp_power_off_reg <= cmp_power_off_next;
      cmp_bandgap_select_reg <= cmp_bandgap_select_next;
      cmp_event_flag_reg <= cmp_event_flag_next;
      cmp_irq_enable_reg <= cmp_irq_enable_next;
      cmp_to_capture_enable_reg <= cmp_to_capture_enable_next;
      mode_reg <= mode_next;
      neg_input_select_reg <= neg_input_select_next;
      buf_off_reg <= buf_off_next;
      irq_status_reg <= irq_status_next;
      irq_mask_reg <= irq_mask_next;
      bus_state_reg <= bus_state_next;
      rdata_reg <= rdata_next;
      err_reg <= err_next;
    end
  end

  // ==========================================
  // analog control bundle
  acmp_analog_ctl_t actl;
  assign actl = '{power_off: cmp_power_off_reg, bandgap_select: cmp_bandgap_select_reg,
                  neg_input_select: neg_input_select_reg,
                  pos_buf_off: buf_off_reg[`ACMP_BIT_POS_BUF_OFF],
                  neg_buf_off: buf_off_reg[`ACMP_BIT_NEG_BUF_OFF]};

  // ==========================================
  // outputs
  assign CMP_POWER_OFF = actl.power_off; // RULE_02
  assign CMP_BANDGAP_SELECT = actl.bandgap_select; // RULE_04
  assign NEG_INPUT_SELECT = actl.neg_input_select; // RULE_15
  assign POS_PIN_BUFFER_OFF = actl.pos_buf_off; // RULE_16
  assign NEG_PIN_BUFFER_OFF = actl.neg_buf_off; // RULE_16
  // pin reads forced low while buffer off
  assign POS_PIN_READ = pos_pin_sync_reg[1] & ~actl.pos_buf_off; // RULE_16
  assign NEG_PIN_READ = neg_pin_sync_reg[1] & ~actl.neg_buf_off; // RULE_16
  // cpu interrupt request gated by flag, enable and global bit
  assign CMP_IRQ_REQ = cmp_event_flag_reg & cmp_irq_enable_reg & CPU_GLOBAL_IRQ_EN; // RULE_09
  // capture source only when routed
  assign CAPTURE_SRC_VALID = cmp_to_capture_enable_reg; // RULE_10
  assign CAPTURE_SRC_LEVEL = cmp_to_capture_enable_reg & cmp_result_sync; // RULE_11
  assign IRQ = |(irq_status_reg & irq_mask_reg);
  assign AVS_READDATA = rdata_reg;
  assign AVS_RESPONSE_ERR = err_reg;
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & (bus_state_reg != ACMP_BUS_DONE);

endmodule : acmp_control

/* File: test/acmp_cmp_model.sv */
// behavioural analog comparator core facing the control block
`timescale 1ns/1ps
module acmp_cmp_model #(
  parameter logic [7:0] GAP_LVL = 8'hD0
) (
  // controls from the block
  input wire logic power_off,
  input wire logic bandgap_select,
  input wire logic [2:0] neg_input_select,
  // analog level and result
  input wire logic [7:0] pos_lvl,
  output logic raw_out
);
  logic [7:0] pos_in;
  logic [7:0] neg_in;
  // input muxes; reserved codes pick a level nothing exceeds
  assign pos_in = bandgap_select ? GAP_LVL : pos_lvl;
  assign neg_in = (neg_input_select > 3'h5) ? 8'hFF : 8'h20 * (neg_input_select + 8'h01);
  // result low while unpowered
  assign raw_out = !power_off && (pos_in > neg_in);
endmodule : acmp_cmp_model

/* File: test/acmp_control_asserts.sv */
// port assertions of the comparator control block
`timescale 1ns/1ps
module acmp_control_asserts (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic CLK_EN,
  // bus
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST,
  // comparator, pins, interrupts, capture
  input wire logic CMP_RAW_OUT,
  input wire logic POS_INPUT_PIN_DIG,
  input wire logic POS_PIN_BUFFER_OFF,
  input wire logic NEG_PIN_BUFFER_OFF,
  input wire logic POS_PIN_READ,
  input wire logic NEG_PIN_READ,
  input wire logic CPU_GLOBAL_IRQ_EN,
  input wire logic CPU_VECTOR_ACK,
  input wire logic CMP_IRQ_REQ,
  input wire logic CAPTURE_SRC_VALID,
  input wire logic CAPTURE_SRC_LEVEL
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  // ==========================================
  // interrupt gating
  irq_gate_a: assert property (CMP_IRQ_REQ |-> CPU_GLOBAL_IRQ_EN)
    else $error("irq request without global enable");
  ack_clear_a: assert property (((CLK_EN && $stable(CMP_RAW_OUT))[*4] ##0 CPU_VECTOR_ACK)
    |=> !CMP_IRQ_REQ) else $error("vector ack left request up");
  // ==========================================
  // capture routing
  cap_off_a: assert property (!CAPTURE_SRC_VALID |-> !CAPTURE_SRC_LEVEL)
    else $error("capture level while disconnected");
  cap_track_a: assert property ((CAPTURE_SRC_VALID && CLK_EN)[*3] |->
    CAPTURE_SRC_LEVEL == $past(CMP_RAW_OUT, 2)) else $error("capture level lags wrongly");
  // ==========================================
  // pin buffers
  pos_off_a: assert property (POS_PIN_BUFFER_OFF |-> !POS_PIN_READ)
    else $error("pos pin reads high while off");
  neg_off_a: assert property (NEG_PIN_BUFFER_OFF |-> !NEG_PIN_READ)
    else $error("neg pin reads high while off");
  pin_pass_a: assert property ((!POS_PIN_BUFFER_OFF && CLK_EN)[*3] |->
    POS_PIN_READ == $past(POS_INPUT_PIN_DIG, 2)) else $error("pos pin read mismatch");
  // ==========================================
  // bus answer timing
  bus_wait_a: assert property (((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && CLK_EN)
    |=> !AVS_WAITREQUEST) else $error("bus answer late");
  // main scenarios
  cover property (CMP_IRQ_REQ);
  cover property (CAPTURE_SRC_VALID && CAPTURE_SRC_LEVEL);
  cover property (POS_PIN_BUFFER_OFF && NEG_PIN_BUFFER_OFF);
endmodule : acmp_control_asserts
bind acmp_control acmp_control_asserts u_asserts (
  .SYS_CLK(SYS_CLK), .RESETN(RESETN), .CLK_EN(CLK_EN), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST), .CMP_RAW_OUT(CMP_RAW_OUT),
  .POS_INPUT_PIN_DIG(POS_INPUT_PIN_DIG), .POS_PIN_BUFFER_OFF(POS_PIN_BUFFER_OFF),
  .NEG_PIN_BUFFER_OFF(NEG_PIN_BUFFER_OFF), .POS_PIN_READ(POS_PIN_READ),
  .NEG_PIN_READ(NEG_PIN_READ), .CPU_GLOBAL_IRQ_EN(CPU_GLOBAL_IRQ_EN),
  .CPU_VECTOR_ACK(CPU_VECTOR_ACK), .CMP_IRQ_REQ(CMP_IRQ_REQ),
  .CAPTURE_SRC_VALID(CAPTURE_SRC_VALID), .CAPTURE_SRC_LEVEL(CAPTURE_SRC_LEVEL));

/* File: test/tb_top.sv */
// self-checking bench for the comparator control block
`timescale 1ns/1ps
module tb_top
  import acmp_pkg::*;
;
  logic sys_clk = 1'b0, resetn = 1'b0, rd = 1'b0, wr = 1'b0;
  logic pin_pos = 1'b0, pin_neg = 1'b0, glob = 1'b0, ack = 1'b0;
  logic [7:0] addr = 8'h00, pos_lvl = 8'h00;
  logic [31:0] wdata = 32'h0, rdata_bus, rdata;
  logic wait_req, err, rerr, raw, pwr_off, gap_sel, pos_off, neg_off;
  logic pos_read, neg_read, irq_req, cap_valid, cap_level, irq;
  logic [2:0] neg_sel;
  int err_total = 0;
  int checked = 0;
  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;
  acmp_control DUT (.SYS_CLK(sys_clk), .RESETN(resetn), .CLK_EN(1'b1), .AVS_ADDRESS(addr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_BYTEENABLE(4'hF), .AVS_WRITEDATA(wdata),
    .AVS_READDATA(rdata_bus), .AVS_WAITREQUEST(wait_req), .AVS_RESPONSE_ERR(err),
    .CMP_RAW_OUT(raw), .CMP_POWER_OFF(pwr_off), .CMP_BANDGAP_SELECT(gap_sel),
    .NEG_INPUT_SELECT(neg_sel), .POS_INPUT_PIN_DIG(pin_pos), .NEG_INPUT_PIN_ONE_DIG(pin_neg),
    .POS_PIN_BUFFER_OFF(pos_off), .NEG_PIN_BUFFER_OFF(neg_off), .POS_PIN_READ(pos_read),
    .NEG_PIN_READ(neg_read), .CPU_GLOBAL_IRQ_EN(glob), .CPU_VECTOR_ACK(ack),
    .CMP_IRQ_REQ(irq_req), .CAPTURE_SRC_VALID(cap_valid), .CAPTURE_SRC_LEVEL(cap_level),
    .IRQ(irq));
  acmp_cmp_model u_model (.power_off(pwr_off), .bandgap_select(gap_sel),
    .neg_input_select(neg_sel), .pos_lvl(pos_lvl), .raw_out(raw));
  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one avalon cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= {24'h0, d};
    // waitrequest and read data are taken at the rising edge itself
    @(posedge sys_clk);
    while (wait_req !== 1'b0) begin
      n++;
      if (n >= 50) begin
        err_total++;
        finish_test();
      end
      @(posedge sys_clk);
    end
    rdata = rdata_bus;
    rerr = err;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  // reset values, read-only result bit, unmapped address
  task automatic t_reset();
    bus(1'b1, 8'hC0, 8'h20);
    bus(1'b0, 8'hC0, 8'h00);
    chk("ctrl", rdata, 32'h0);
    bus(1'b0, 8'hC4, 8'h00);
    chk("sel", rdata, 32'h0);
    bus(1'b0, 8'hC8, 8'h00);
    chk("dis", rdata, 32'h0);
    bus(1'b0, 8'hFC, 8'h00);
    chk("err", rerr, 1'b1);
  endtask : t_reset
  // every negative input code, then the bandgap
  task automatic t_mux();
    pos_lvl <= 8'h70;
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, 8'hC4, 8'(i));
      cyc(4);
      chk("neg_sel", neg_sel, 32'(i));
      bus(1'b0, 8'hC0, 8'h00);
      chk("result", rdata[5], 32'(8'h70 > 8'h20 * (i + 1)));
    end
    bus(1'b1, 8'hC0, 8'h40);
    cyc(4);
    bus(1'b0, 8'hC0, 8'h00);
    chk("gap", {gap_sel, rdata[5]}, 32'h3);
    bus(1'b1, 8'hC0, 8'h00);
  endtask : t_mux
  // flag per event mode, write-zero keeps, write-one clears
  task automatic t_modes();
    acmp_mode_t md[4] = '{ACMP_MODE_TOGGLE, ACMP_MODE_FALL, ACMP_MODE_RISE, ACMP_MODE_RESVD};
    logic er[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic ef[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    bus(1'b1, 8'hC4, 8'h03);
    for (int i = 0; i < 4; i++) begin
      pos_lvl <= 8'h00;
      cyc(5);
      bus(1'b1, 8'hC0, {6'h04, md[i]});
      pos_lvl <= 8'hF0;
      cyc(5);
      bus(1'b0, 8'hC0, 8'h00);
      chk("rise_flag", rdata[4], er[i]);
      bus(1'b1, 8'hC0, {6'h00, md[i]});
      bus(1'b0, 8'hC0, 8'h00);
      chk("kept_flag", rdata[4], er[i]);
      bus(1'b1, 8'hC0, {6'h04, md[i]});
      bus(1'b0, 8'hC0, 8'h00);
      chk("clr_flag", rdata[4], 1'b0);
      pos_lvl <= 8'h00;
      cyc(5);
      bus(1'b0, 8'hC0, 8'h00);
      chk("fall_flag", rdata[4], ef[i]);
    end
  endtask : t_modes
  // request gating, vector clear, status clear on read, mask
  task automatic t_irq();
    bus(1'b0, 8'hCC, 8'h00);
    bus(1'b1, 8'hC4, 8'h06);
    bus(1'b0, 8'hCC, 8'h00);
    chk("resvd_sel", rdata, 32'h2);
    bus(1'b1, 8'hC4, 8'h03);
    bus(1'b0, 8'hCC, 8'h00);
    chk("status_clr", rdata, 32'h0);
    bus(1'b1, 8'hD0, 8'h01);
    bus(1'b1, 8'hC0, 8'h1B);
    glob <= 1'b1;
    pos_lvl <= 8'hF0;
    cyc(5);
    chk("irq_req", {irq_req, irq}, 32'h3);
    glob <= 1'b0;
    cyc(1);
    chk("irq_glob", irq_req, 1'b0);
    glob <= 1'b1;
    ack <= 1'b1;
    cyc(1);
    ack <= 1'b0;
    cyc(1);
    chk("irq_ack", irq_req, 1'b0);
    bus(1'b0, 8'hCC, 8'h00);
    chk("status", {rdata[1:0], irq}, 32'h2);
    bus(1'b1, 8'hD0, 8'h00);
    bus(1'b1, 8'hC0, 8'h10);
  endtask : t_irq
  // capture routing, pin buffers, power off
  task automatic t_cap_pins();
    bus(1'b1, 8'hC0, 8'h04);
    cyc(4);
    chk("cap_on", {cap_valid, cap_level}, 32'h3);
    bus(1'b1, 8'hC0, 8'h00);
    chk("cap_off", {cap_valid, cap_level}, 32'h0);
    pin_pos <= 1'b1;
    pin_neg <= 1'b1;
    cyc(4);
    chk("pins_on", {pos_read, neg_read}, 32'h3);
    bus(1'b1, 8'hC8, 8'h03);
    bus(1'b0, 8'hC8, 8'h00);
    chk("pins_off", {rdata[1:0], pos_off, neg_off, pos_read, neg_read}, 32'h3C);
    bus(1'b1, 8'hC0, 8'h80);
    cyc(4);
    bus(1'b0, 8'hC0, 8'h00);
    chk("power_off", {pwr_off, rdata[7], rdata[5]}, 32'h6);
  endtask : t_cap_pins
  task automatic finish_test();
    if (err_total == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  // watchdog
  initial begin
    #2000000;
    err_total++;
    finish_test();
  end
  // main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset();
    t_mux();
    t_modes();
    t_irq();
    t_cap_pins();
    finish_test();
  end
endmodule : tb_top
